// *** inc/aisp_defines.vh ***
// Register map, fields, reset values and timing counts
`ifndef AISP_DEFINES_VH
`define AISP_DEFINES_VH

// Register indexes; byte address is four times the index
`define AISP_IDX_CTRL0 9'd0
`define AISP_IDX_CTRL1 9'd1
`define AISP_IDX_CTRL2 9'd2
`define AISP_IDX_STATUS 9'd3
`define AISP_IDX_TRAP_L 9'd263
`define AISP_IDX_TRAP_R 9'd264
`define AISP_IDX_TEST 9'd511

// Reset values: all zero
`define AISP_CTRL_RST 16'h0000
`define AISP_TRAP_RST 10'h000

// Control register 0 fields
`define AISP_C0_FMT_HI 3
`define AISP_C0_FMT_LO 0
// Control register 1 fields
`define AISP_C1_DEEMP_SW 0
`define AISP_C1_AUX_EN 11
// Control register 2 fields
`define AISP_C2_PASS_EN 8
`define AISP_C2_IN_SEL_HI 7
`define AISP_C2_IN_SEL_LO 6
`define AISP_C2_MCK_SEL_HI 5
`define AISP_C2_MCK_SEL_LO 4
`define AISP_C2_RATIO 2
`define AISP_C2_MCKO_HI 1
`define AISP_C2_MCKO_LO 0

// Serial formats
`define AISP_FMT_I2S 4'h0

// Master clock output modes
`define AISP_MCKO_256 2'h1
`define AISP_MCKO_512 2'h2
`define AISP_MCKO_COPY 2'h3

// Test value that routes noise out
`define AISP_TEST_NOISE 16'h0007

// Timing counts
`define AISP_INIT_MCLKS 11'd1024
`define AISP_ZERO_FRAMES 11'd1024
`define AISP_CLK_MHZ 50
`define AISP_RAMP_TIME_US 10000
`define AISP_VOL_MAX 10'h3ff
`define AISP_RAMP_STEPS 1024
`define AISP_STEP_CYCLES ((`AISP_RAMP_TIME_US * `AISP_CLK_MHZ) / `AISP_RAMP_STEPS)

`endif

// *** hdl/aisp_sync.v ***
// Two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module aisp_sync #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  // First stage feeds only the second stage
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // Both stages clear on reset
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // aisp_sync

// *** hdl/aisp_lfsr.v ***
// 24-bit pseudo-random noise shift register
`timescale 1ns/1ps
module aisp_lfsr #(
  parameter WIDTH = 24
) (
  input wire clk_in,
  input wire nrst_in,
  input wire step_in,
  output wire bit_out
);
  // Seed must be nonzero or the sequence locks up
  reg [WIDTH-1:0] state_reg;
  wire fb;

  // Taps 24,23,22,17 give a maximal length sequence
  assign fb = state_reg[23] ^ state_reg[22] ^ state_reg[21] ^ state_reg[16];

  // Advance one bit per step strobe
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (step_in) begin
      state_reg <= {state_reg[WIDTH-2:0], fb};
    end
  end

  assign bit_out = state_reg[WIDTH-1];
endmodule // aisp_lfsr

// *** hdl/aisp_top.v ***
// Audio input and clock select, pin control, APB registers
// Summary of operation
// [R1] Ctrl2 bits 7:6 pick frame/bit clocks
// [R2] Selected clocks read per chosen format
// [R3] Pass-through pins held low unless enabled
// [R4] Ctrl2 bits 5:4 pick master clock
// [R5] Ctrl2 bit 2 sets 256/512 ratio
// [R6] Master clock output mode, 00 off
// [R7] Readback pin undriven outside reads
// [R8] Works with stopped control-port clock
// [R9] Host frames transactions with latch low
// [R10] Transfer length follows address and direction
// [R11] Reset clears registers and captured data
// [R12] Init done after 1024 master clocks
// [R13] Host waits for init before writing
// [R14] Master clock zero runs at power-up
// [R15] Zero flag after 1024 silent frames
// [R16] Test value 7 routes noise out
// [R17] Noise at 128 fs, 2^24-1 period
// [R18] Program counter trap loads capture words
// [R19] Capture output uses input format, clocks
// [R20] Pin high inserts de-emphasis filter
// [R21] Ctrl1 bit 11 makes pin aux input
// [R22] Mute ramps volume over 10 ms
// [R23] Same bits pick serial data input
// [R24] Ctrl0 bits 3:0 set serial format
// [R25] Nonzero data clears flag, restarts count
`timescale 1ns/1ps
`include "aisp_defines.vh"
module aisp_top #(
  parameter PC_W = 10,
  parameter WORD_W = 24
) (
  input wire clk_in,
  input wire nrst_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // Serial audio input groups
  input wire [2:0] frame_clock_in,
  input wire [2:0] bit_clock_in,
  input wire [2:0] serial_audio_in,
  input wire [2:0] master_clock_in,
  input wire deemphasis_or_aux_in,
  input wire mute_in,
  // Control-port pins and readback from the port decoder
  input wire control_port_latch_in,
  input wire cport_read_active_in,
  input wire cport_read_bit_in,
  // DSP core taps
  input wire [PC_W-1:0] dsp_pc_in,
  input wire [WORD_W-1:0] dsp_tap_in,
  // Pin outputs
  output wire passthru_frame_clock_out,
  output wire passthru_bit_clock_out,
  output wire passthru_serial_audio_out,
  output wire master_clock_output_out,
  output wire control_port_readback_out,
  output wire control_port_readback_oe_out,
  output wire zero_input_indicator_out,
  output wire capture_serial_output_out,
  output wire aux_serial_data_out,
  output wire deemphasis_active_out,
  output wire init_done_out,
  output wire [9:0] volume_gain_out
);
  localparam integer STEP_INT = `AISP_STEP_CYCLES;
  localparam [9:0] STEP_CYC = STEP_INT[9:0];

  // Registers
  reg [15:0] ctrl0_reg;
  reg [15:0] ctrl1_reg;
  reg [15:0] ctrl2_reg;
  reg [15:0] test_reg;
  reg [PC_W-1:0] trap_l_reg;
  reg [PC_W-1:0] trap_r_reg;
  // APB answer flops
  reg pready_reg;
  reg pslverr_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rd_mux;
  reg rd_hit;
  // Synchronised pins
  wire [14:0] pins_s;
  wire [2:0] s_mclk;
  wire [2:0] s_lr;
  wire [2:0] s_bclk;
  wire [2:0] s_data;
  wire s_aux;
  wire s_mute;
  wire s_latch;
  // Selected group
  reg sel_lr;
  reg sel_bclk;
  reg sel_data;
  reg sel_mclk;
  // Edge history
  reg mclk_d_reg;
  reg lr_d_reg;
  reg bclk_d_reg;
  wire mclk_rise;
  wire lr_rise;
  wire lr_edge;
  wire bclk_rise;
  wire bclk_fall;
  // Control fields
  wire [3:0] fmt;
  wire aux_en;
  wire ratio256;
  wire [1:0] mcko_mode;
  wire [8:0] idx;
  wire apb_done;
  // Init, zero detect, noise, capture, mute state
  reg [10:0] init_cnt_reg;
  reg init_done_reg;
  reg [10:0] zero_cnt_reg;
  reg zero_flag_reg;
  reg frame_nz_reg;
  reg [1:0] nz_div_reg;
  wire noise_bit;
  wire noise_step;
  reg [WORD_W-1:0] cap_l_reg;
  reg [WORD_W-1:0] cap_r_reg;
  reg [WORD_W-1:0] shift_reg;
  reg cap_out_reg;
  reg [9:0] vol_reg;
  reg [9:0] step_cnt_reg;
  reg div2_reg;
  // Output flops
  reg pass_lr_reg;
  reg pass_bclk_reg;
  reg pass_data_reg;
  reg mcko_reg;
  reg rb_reg;
  reg rb_oe_reg;
  reg zero_pin_reg;
  reg aux_reg;
  reg deemp_reg;
  wire in_bit_nz;
  wire left_phase;

  // One synchroniser bank for every pin input
  aisp_sync #(
    .WIDTH(15)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in({control_port_latch_in, mute_in, deemphasis_or_aux_in,
      serial_audio_in, bit_clock_in, frame_clock_in, master_clock_in}),
    .sync_out(pins_s)
  );
  assign s_mclk = pins_s[2:0];
  assign s_lr = pins_s[5:3];
  assign s_bclk = pins_s[8:6];
  assign s_data = pins_s[11:9];
  assign s_aux = pins_s[12];
  assign s_mute = pins_s[13];
  assign s_latch = pins_s[14];

  assign fmt = ctrl0_reg[`AISP_C0_FMT_HI:`AISP_C0_FMT_LO];
  assign aux_en = ctrl1_reg[`AISP_C1_AUX_EN];
  assign ratio256 = ctrl2_reg[`AISP_C2_RATIO];
  assign mcko_mode = ctrl2_reg[`AISP_C2_MCKO_HI:`AISP_C2_MCKO_LO];

  // Input group and master clock muxes; code 11 falls back to group zero
  always @* begin
    // [R1] frame/bit clock select
    // [R23] data input select
    case (ctrl2_reg[`AISP_C2_IN_SEL_HI:`AISP_C2_IN_SEL_LO])
      2'h1: begin
        sel_lr = s_lr[1];
        sel_bclk = s_bclk[1];
        sel_data = s_data[1];
      end
      2'h2: begin
        sel_lr = s_lr[2];
        sel_bclk = s_bclk[2];
        sel_data = s_data[2];
      end
      default: begin
        sel_lr = s_lr[0];
        sel_bclk = s_bclk[0];
        sel_data = s_data[0];
      end
    endcase
    // [R4] master clock select
    case (ctrl2_reg[`AISP_C2_MCK_SEL_HI:`AISP_C2_MCK_SEL_LO])
      2'h1: sel_mclk = s_mclk[1];
      2'h2: sel_mclk = s_mclk[2];
      default: sel_mclk = s_mclk[0];
    endcase
  end

  // Edge history of the selected clocks
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      mclk_d_reg <= 1'b0;
      lr_d_reg <= 1'b0;
      bclk_d_reg <= 1'b0;
    end else begin
      mclk_d_reg <= sel_mclk;
      lr_d_reg <= sel_lr;
      bclk_d_reg <= sel_bclk;
    end
  end
  assign mclk_rise = sel_mclk & ~mclk_d_reg;
  assign lr_rise = sel_lr & ~lr_d_reg;
  assign lr_edge = sel_lr ^ lr_d_reg;
  assign bclk_rise = sel_bclk & ~bclk_d_reg;
  assign bclk_fall = ~sel_bclk & bclk_d_reg;

  // APB decode; index sits in address bits 10:2
  assign idx = paddr_in[10:2];
  assign apb_done = psel_in & penable_in & pready_reg;

  // Read mux; unmapped addresses flag an error
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = ~paddr_in[11];
    case (idx)
      `AISP_IDX_CTRL0: rd_mux = {16'h0000, ctrl0_reg};
      `AISP_IDX_CTRL1: rd_mux = {16'h0000, ctrl1_reg};
      `AISP_IDX_CTRL2: rd_mux = {16'h0000, ctrl2_reg};
      `AISP_IDX_STATUS: rd_mux = {20'h00000, zero_flag_reg, init_done_reg,
        vol_reg};
      `AISP_IDX_TRAP_L: rd_mux = {{(32-PC_W){1'b0}}, trap_l_reg};
      `AISP_IDX_TRAP_R: rd_mux = {{(32-PC_W){1'b0}}, trap_r_reg};
      `AISP_IDX_TEST: rd_mux = {16'h0000, test_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // One wait state: pready in second access cycle
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel_in & penable_in & ~pready_reg;
      pslverr_reg <= psel_in & penable_in & ~pready_reg & ~rd_hit;
      if (psel_in & penable_in & ~pready_reg & ~pwrite_in) begin
        prdata_reg <= rd_hit ? rd_mux : 32'h00000000;
      end
    end
  end

  // Register writes land on the completing edge only
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      // [R11] registers clear on reset
      ctrl0_reg <= `AISP_CTRL_RST;
      ctrl1_reg <= `AISP_CTRL_RST;
      ctrl2_reg <= `AISP_CTRL_RST;
      test_reg <= `AISP_CTRL_RST;
      trap_l_reg <= `AISP_TRAP_RST;
      trap_r_reg <= `AISP_TRAP_RST;
    end else if (apb_done & pwrite_in & ~paddr_in[11]) begin
      case (idx)
        `AISP_IDX_CTRL0: ctrl0_reg <= pwdata_in[15:0];
        `AISP_IDX_CTRL1: ctrl1_reg <= pwdata_in[15:0];
        `AISP_IDX_CTRL2: ctrl2_reg <= pwdata_in[15:0];
        `AISP_IDX_TRAP_L: trap_l_reg <= pwdata_in[PC_W-1:0];
        `AISP_IDX_TRAP_R: trap_r_reg <= pwdata_in[PC_W-1:0];
        `AISP_IDX_TEST: test_reg <= pwdata_in[15:0];
        default: ;
      endcase
    end
  end

  // Init counter runs on the selected master clock
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      init_cnt_reg <= 11'h000;
      init_done_reg <= 1'b0;
    end else if (~init_done_reg & mclk_rise) begin
      // [R12] done after 1024 master clocks
      if (init_cnt_reg == `AISP_INIT_MCLKS - 11'h001) begin
        init_done_reg <= 1'b1;
      end
      init_cnt_reg <= init_cnt_reg + 11'h001;
    end
  end

  // Any nonzero bit on either serial input in this bit slot
  assign in_bit_nz = sel_data | (aux_en & s_aux);

  // Zero-input detector counts frame clock cycles of silence
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      zero_cnt_reg <= 11'h000;
      zero_flag_reg <= 1'b0;
      frame_nz_reg <= 1'b0;
    end else if (bclk_rise & in_bit_nz) begin
      // [R25] nonzero data clears flag
      zero_cnt_reg <= 11'h000;
      zero_flag_reg <= 1'b0;
      frame_nz_reg <= 1'b1;
    end else if (lr_rise) begin
      frame_nz_reg <= 1'b0;
      // [R15] flag after 1024 silent frames
      if (frame_nz_reg) begin
        zero_cnt_reg <= 11'h000;
      end else if (zero_cnt_reg == `AISP_ZERO_FRAMES - 11'h001) begin
        zero_flag_reg <= 1'b1;
      end else begin
        zero_cnt_reg <= zero_cnt_reg + 11'h001;
      end
    end
  end

  // [R17] noise steps every 4 (512 fs) or 2 (256 fs) master clocks
  assign noise_step = mclk_rise &
    (ratio256 ? nz_div_reg[0] : (nz_div_reg == 2'h3));
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      nz_div_reg <= 2'h0;
    end else if (mclk_rise) begin
      nz_div_reg <= nz_div_reg + 2'h1;
    end
  end

  aisp_lfsr #(
    .WIDTH(24)
  ) u_lfsr (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .step_in(noise_step),
    .bit_out(noise_bit)
  );

  // [R18] trap compare loads capture words
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      cap_l_reg <= {WORD_W{1'b0}};
      cap_r_reg <= {WORD_W{1'b0}};
    end else begin
      if (dsp_pc_in == trap_l_reg) begin
        cap_l_reg <= dsp_tap_in;
      end
      if (dsp_pc_in == trap_r_reg) begin
        cap_r_reg <= dsp_tap_in;
      end
    end
  end

  // [R2] I2S frames left on low, other formats on high
  assign left_phase = (fmt == `AISP_FMT_I2S) ? ~sel_lr : sel_lr;

  // Capture shifter: MSB first, changes on falling bit clock
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      shift_reg <= {WORD_W{1'b0}};
      cap_out_reg <= 1'b0;
    end else if (lr_edge) begin
      // [R19] frame start follows input format
      // [R24] I2S delays the MSB by one bit
      if (fmt == `AISP_FMT_I2S) begin
        shift_reg <= left_phase ? cap_l_reg : cap_r_reg;
        cap_out_reg <= 1'b0;
      end else begin
        shift_reg <= {(left_phase ? cap_l_reg[WORD_W-2:0] :
          cap_r_reg[WORD_W-2:0]), 1'b0};
        cap_out_reg <= left_phase ? cap_l_reg[WORD_W-1] :
          cap_r_reg[WORD_W-1];
      end
    end else if (bclk_fall) begin
      cap_out_reg <= shift_reg[WORD_W-1];
      shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
    end
  end

  // [R22] mute ramp, one step per STEP_CYC clocks
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      vol_reg <= `AISP_VOL_MAX;
      step_cnt_reg <= 10'h000;
    end else if (step_cnt_reg == STEP_CYC - 10'h001) begin
      step_cnt_reg <= 10'h000;
      if (s_mute & (vol_reg != 10'h000)) begin
        vol_reg <= vol_reg - 10'h001;
      end else if (~s_mute & (vol_reg != `AISP_VOL_MAX)) begin
        vol_reg <= vol_reg + 10'h001;
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 10'h001;
    end
  end

  // Halved master clock for 256 fs from a 512 fs input
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      div2_reg <= 1'b0;
    end else if (mclk_rise) begin
      div2_reg <= ~div2_reg;
    end
  end

  // Pin output flops
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      pass_lr_reg <= 1'b0;
      pass_bclk_reg <= 1'b0;
      pass_data_reg <= 1'b0;
      mcko_reg <= 1'b0;
      rb_reg <= 1'b0;
      rb_oe_reg <= 1'b0;
      zero_pin_reg <= 1'b0;
      aux_reg <= 1'b0;
      deemp_reg <= 1'b0;
    end else begin
      // [R3] pass-through held low unless enabled
      pass_lr_reg <= ctrl2_reg[`AISP_C2_PASS_EN] & sel_lr;
      pass_bclk_reg <= ctrl2_reg[`AISP_C2_PASS_EN] & sel_bclk;
      pass_data_reg <= ctrl2_reg[`AISP_C2_PASS_EN] & sel_data;
      // [R6] master clock output mode
      // [R5] ratio picks the 256 fs source
      case (mcko_mode)
        `AISP_MCKO_256: mcko_reg <= ratio256 ? sel_mclk : div2_reg;
        `AISP_MCKO_512: mcko_reg <= sel_mclk;
        `AISP_MCKO_COPY: mcko_reg <= sel_mclk;
        default: mcko_reg <= 1'b0;
      endcase
      // [R7] drive only during an active read
      // [R8] latch level only, no control clock edges
      // [R10] read length comes from the port decoder
      rb_oe_reg <= cport_read_active_in & ~s_latch;
      rb_reg <= cport_read_active_in & ~s_latch & cport_read_bit_in;
      // [R16] test value 7 selects noise
      zero_pin_reg <= (test_reg == `AISP_TEST_NOISE) ? noise_bit :
        zero_flag_reg;
      // [R21] aux mode routes pin to serial data
      aux_reg <= aux_en & s_aux;
      // [R20] pin high inserts de-emphasis
      deemp_reg <= aux_en ? ctrl1_reg[`AISP_C1_DEEMP_SW] : s_aux;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign passthru_frame_clock_out = pass_lr_reg;
  assign passthru_bit_clock_out = pass_bclk_reg;
  assign passthru_serial_audio_out = pass_data_reg;
  assign master_clock_output_out = mcko_reg;
  assign control_port_readback_out = rb_reg;
  assign control_port_readback_oe_out = rb_oe_reg;
  assign zero_input_indicator_out = zero_pin_reg;
  assign capture_serial_output_out = cap_out_reg;
  assign aux_serial_data_out = aux_reg;
  assign deemphasis_active_out = deemp_reg;
  assign init_done_out = init_done_reg;
  assign volume_gain_out = vol_reg;
endmodule // aisp_top

// *** test/aisp_top_assertions.sv ***
// Checks on the pin control block's ports
`timescale 1ns/1ps
module aisp_top_checker (
  input wire clk_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire pslverr_out,
  input wire cport_read_active_in,
  input wire passthru_frame_clock_out,
  input wire passthru_bit_clock_out,
  input wire passthru_serial_audio_out,
  input wire master_clock_output_out,
  input wire control_port_readback_oe_out,
  input wire init_done_out,
  input wire [9:0] volume_gain_out
);
  // Control 2 shadow, set on commit
  reg [8:0] c2_reg;
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      c2_reg <= 9'h000;
    end else if (psel_in && penable_in && pready_out && pwrite_in &&
        paddr_in == 12'h008) begin
      c2_reg <= pwdata_in[8:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_pass_off;
    !c2_reg[8] && !$past(c2_reg[8]) |-> !(passthru_frame_clock_out ||
      passthru_bit_clock_out || passthru_serial_audio_out);
  endproperty
  a_pass_off: assert property (p_pass_off)
    else $error("pass pins on");
  property p_oe_idle;
    !cport_read_active_in |=> !control_port_readback_oe_out;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("oe with no read");
  property p_init_hold;
    init_done_out |=> init_done_out;
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("init done fell");
  // Ready in second access cycle
  property p_wait;
    psel_in && penable_in && !$past(penable_in) |-> !pready_out ##1 pready_out;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait state");
  property p_ready_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready too long");
  property p_err_addr;
    pready_out && paddr_in[11] |-> pslverr_out;
  endproperty
  a_err_addr: assert property (p_err_addr)
    else $error("high addr ok");
  property p_err_ready;
    pslverr_out |-> pready_out;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("err no ready");
  // Three settled cycles for the pin flop
  property p_mcko_off;
    c2_reg[1:0] == 2'h0 && $past(c2_reg[1:0]) == 2'h0 &&
      $past(c2_reg[1:0], 2) == 2'h0 |-> !master_clock_output_out;
  endproperty
  a_mcko_off: assert property (p_mcko_off)
    else $error("mcko while off");
  property p_vol_step;
    $changed(volume_gain_out) |-> volume_gain_out - $past(volume_gain_out)
      == 10'h001 || $past(volume_gain_out) - volume_gain_out == 10'h001;
  endproperty
  a_vol_step: assert property (p_vol_step)
    else $error("vol jump");
  property p_vol_hold;
    $changed(volume_gain_out) |=> $stable(volume_gain_out)[*8];
  endproperty
  a_vol_hold: assert property (p_vol_hold)
    else $error("vol too fast");
endmodule // aisp_top_checker

bind aisp_top aisp_top_checker i_chk (.*);

// *** test/aisp_audio_source.sv ***
// Serial audio source and master clock for one input group
`timescale 1ns/1ps
module aisp_audio_source #(
  parameter integer HALF = 32,
  parameter [23:0] WORD = 24'h000000,
  parameter integer MCK = 100
) (
  input wire zero_in,
  output logic frame_clock_out,
  output logic bit_clock_out,
  output logic serial_audio_out,
  output logic master_clock_out
);
  integer i;
  initial begin
    master_clock_out = 1'b0;
    #3;
    forever #(MCK / 2) master_clock_out = ~master_clock_out;
  end
  // Frame and data change on bit clock fall
  initial begin
    frame_clock_out = 1'b0;
    bit_clock_out = 1'b0;
    serial_audio_out = 1'b0;
    #7;
    forever begin
      for (i = 0; i < 2 * HALF; i = i + 1) begin
        frame_clock_out = (i >= HALF);
        // Bits past the word are zero
        serial_audio_out = !zero_in && (i % HALF) < 24 &&
          WORD[23 - (i % HALF)];
        #80 bit_clock_out = 1'b1;
        #80 bit_clock_out = 1'b0;
      end
    end
  end
endmodule // aisp_audio_source

// *** test/test_aisp_top.sv ***
// Self-checking bench for the audio pin control block
`timescale 1ns/1ps
module test_aisp_top;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, q;
  logic e, a, zero2 = 1'b0;
  logic aux_in = 1'b0, mute_in = 1'b0, latch_n = 1'b1;
  logic rd_act = 1'b0, rd_bit = 1'b0;
  logic [9:0] pc = 10'h000;
  logic [23:0] tap = 24'h000000;
  logic [2:0] h0, h1, h2;
  wire [31:0] prdata_out;
  wire [2:0] fck, bck, sda, mck;
  wire pready_out, pslverr_out, pf, pb, pd, mco, rb, rb_oe, zf, cso, de;
  wire idone, ax;
  wire [9:0] vol;
  integer err_count = 0, samples_checked = 0, g = 0, mk = 0;
  integer i, k, n, m;
  // Control 2 settings and output divide: 0 off
  logic [8:0] mc [0:4] = '{9'h000, 9'h013, 9'h021, 9'h025, 9'h002};
  integer dv [0:4] = '{0, 1, 2, 1, 1};
  always #10 clk_in = ~clk_in;
  genvar gk;
  // Group 2 has one-bit slots for short frames
  for (gk = 0; gk < 3; gk = gk + 1) begin : g_src
    aisp_audio_source #(.HALF(gk == 2 ? 1 : 32), .WORD(24'ha5c30f ^ gk),
      .MCK(100 + 40 * gk)) i_src (.zero_in(gk == 2 ? zero2 : 1'b0),
      .frame_clock_out(fck[gk]), .bit_clock_out(bck[gk]),
      .serial_audio_out(sda[gk]), .master_clock_out(mck[gk]));
  end
  aisp_top i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .frame_clock_in(fck), .bit_clock_in(bck),
    .serial_audio_in(sda), .master_clock_in(mck),
    .deemphasis_or_aux_in(aux_in), .mute_in(mute_in),
    .control_port_latch_in(latch_n), .cport_read_active_in(rd_act),
    .cport_read_bit_in(rd_bit), .dsp_pc_in(pc), .dsp_tap_in(tap),
    .passthru_frame_clock_out(pf), .passthru_bit_clock_out(pb),
    .passthru_serial_audio_out(pd), .master_clock_output_out(mco),
    .control_port_readback_out(rb), .control_port_readback_oe_out(rb_oe),
    .zero_input_indicator_out(zf), .capture_serial_output_out(cso),
    .aux_serial_data_out(ax), .deemphasis_active_out(de),
    .init_done_out(idone), .volume_gain_out(vol)
  );
  // Selected group pins as seen two edges back
  always @(posedge clk_in) begin
    h0 <= {fck[g], bck[g], sda[g]};
    h1 <= h0;
    h2 <= h1;
  end
  // Master clock zero rises before init done
  always @(posedge mck[0]) if (nrst_in && !idone) mk = mk + 1;
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("unexpected at %0t ns: %s got %h", $time, s, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task give_up;
    chk(32'h0, 32'h1, "wait ran out");
    end_of_test;
  endtask
  // One APB transfer, held until ready
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n = n + 1;
    end while (pready_out !== 1'b1 && n < 16);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
    if (n >= 16) give_up;
  endtask
  // One edge, counting group 2 frame rises
  task frame_step;
    @(posedge clk_in);
    n = n + 1;
    if (fck[2] && !a) m = m + 1;
    a = fck[2];
    if (n > 20000) give_up;
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b0, {i[9:0], 2'b00}, 32'h0);
      chk(q, 32'h0, "ctrl reset");
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk(q, 32'h3ff, "status reset");
    n = 0;
    while (idone !== 1'b1 && n < 8000) begin
      @(posedge clk_in);
      n = n + 1;
    end
    chk(mk >= 1023 && mk <= 1025, 1'b1, "init length");
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h3, "format field");
    apb(1'b1, 12'h800, 32'h5);
    chk(e, 1'b1, "high addr");
    apb(1'b0, 12'h014, 32'h0);
    chk(e, 1'b1, "unmapped err");
    chk(q, 32'h0, "unmapped data");
    apb(1'b1, 12'h00c, 32'h0);
    chk(e, 1'b0, "status write");
    $display("register test done");
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 12'h008, 32'h100 | (i << 6));
      g = (i == 3) ? 0 : i;
      repeat (8) @(posedge clk_in);
      m = 0;
      repeat (600) begin
        @(negedge clk_in);
        if ({pf, pb, pd} !== h2) m = m + 1;
      end
      @(posedge clk_in);
      chk(m, 32'h0, "pass copy");
    end
    apb(1'b1, 12'h008, 32'h040);
    m = 0;
    repeat (300) @(posedge clk_in) if (pf || pb || pd) m = m + 1;
    chk(m, 32'h0, "pass off");
    $display("pass test done");
    for (i = 0; i < 5; i = i + 1) begin
      apb(1'b1, 12'h008, {23'h0, mc[i]});
      k = mc[i][5:4];
      repeat (10) @(posedge clk_in);
      n = 0;
      m = 0;
      a = mco;
      e = mck[k];
      repeat (1000) begin
        @(posedge clk_in);
        if (mco && !a) n = n + 1;
        if (mck[k] && !e) m = m + 1;
        a = mco;
        e = mck[k];
      end
      chk(dv[i] == 0 ? n == 0 : n * dv[i] + 3 >= m && n * dv[i] <= m + 3,
        1'b1, "mcko rate");
    end
    $display("mcko test done");
    apb(1'b1, 12'h008, 32'h080);
    zero2 = 1'b1;
    a = fck[2];
    m = 0;
    n = 0;
    while (m < 1000) frame_step;
    chk(zf, 1'b0, "zero flag early");
    while (zf !== 1'b1 && m < 1030) frame_step;
    chk(zf, 1'b1, "zero flag set");
    zero2 = 1'b0;
    repeat (24) @(posedge clk_in);
    chk(zf, 1'b0, "zero flag clear");
    apb(1'b1, 12'h7fc, 32'h7);
    m = 0;
    a = zf;
    repeat (2000) begin
      @(posedge clk_in);
      if (zf !== a) m = m + 1;
      a = zf;
    end
    chk(m > 20, 1'b1, "noise");
    apb(1'b1, 12'h7fc, 32'h0);
    repeat (6) @(posedge clk_in);
    chk(zf, 1'b0, "noise removed");
    $display("zero test done");
    apb(1'b1, 12'h41c, 32'h055);
    pc <= 10'h055;
    tap <= 24'hffffff;
    m = 0;
    repeat (400) @(posedge clk_in) if (cso === 1'b1) m = m + 1;
    chk(m > 0, 1'b1, "capture out");
    aux_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(de, 1'b1, "pin de-emphasis");
    apb(1'b1, 12'h004, 32'h800);
    repeat (6) @(posedge clk_in);
    chk(de, 1'b0, "aux deemph");
    chk(ax, 1'b1, "aux data");
    rd_act <= 1'b1;
    rd_bit <= 1'b1;
    latch_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk({rb_oe, rb}, 2'b11, "readback on");
    latch_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(rb_oe, 1'b0, "readback off");
    rd_act <= 1'b0;
    $display("pin test done");
    mute_in <= 1'b1;
    repeat (2000) @(posedge clk_in);
    chk(vol >= 10'h3fa && vol <= 10'h3fe, 1'b1, "ramp down");
    mute_in <= 1'b0;
    n = 0;
    while (vol !== 10'h3ff && n < 4000) begin
      @(posedge clk_in);
      n = n + 1;
    end
    chk(vol, 32'h3ff, "ramp back");
    nrst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0, "reset clears");
    $display("mute and reset test done");
    end_of_test;
  end
endmodule // test_aisp_top
